// *** hdl/pg_mask_bank.sv ***
// Power-good tree mask bank for status outputs one, four and two.
// Assumes factory configuration arrives on stable straps sampled after
// reset, and rail power-good and control pins arrive asynchronously.
`timescale 1ns/1ps
module pg_mask_bank
   import pg_mask_pkg::*;
(
   input  wire logic              clock,               // 20 MHz logic clock
   input  wire logic              rst,                 // Async reset, active high
   input  wire logic [ADDR_W-1:0] reg_addr,            // Register offset from host port
   input  wire logic              reg_wr,              // Write strobe, one cycle
   input  wire logic              reg_rd,              // Read strobe, one cycle
   input  wire logic [DATA_W-1:0] reg_wdata,           // Write data
   output logic      [DATA_W-1:0] reg_rdata,           // Read data, one cycle after strobe
   output logic                   reg_hit,             // Read or write hit a mask register
   input  wire logic [8*NUM_REGS-1:0] factory_masks,   // Factory reset values, index order
   input  wire logic              factory_shared_sel,  // 1 load switch two, 0 regulator a1
   input  wire logic [2:0]        factory_host_ctrl,   // Host-level mode: out1, out4, out2
   input  wire logic [2:0]        host_level,          // Level bits: out1, out4, out2
   input  wire logic [5:0]        converter_pg,        // Converters six..one power-good
   input  wire logic              switch_a_one_pg,     // Switch a1 power-good
   input  wire logic              regulator_a_two_pg,  // Regulator a2 power-good
   input  wire logic              regulator_a_three_pg, // Regulator a3 power-good
   input  wire logic              regulator_a_one_pg,  // Regulator a1 power-good
   input  wire logic              load_switch_one_pg,  // Load switch one power-good
   input  wire logic              load_switch_two_pg,  // Load switch two power-good
   input  wire logic              termination_regulator_pg, // Termination power-good
   input  wire logic              control_input_one,   // Control pin one state
   input  wire logic              control_input_two,   // Control pin two state
   input  wire logic              control_input_four,  // Control pin four state
   input  wire logic              control_input_five,  // Control pin five state
   output logic                   status_output_one,   // Output one level
   output logic                   status_output_four,  // Output four level
   output logic                   status_output_two    // Output two level
);

   // Width of the synchronised word: six converters, eleven singles, three levels
   localparam int IN_W = 20;

   typedef enum logic [1:0] {
      LOAD_WAIT = 2'b00,
      LOAD_DONE = 2'b01
   } load_state_e;

   // Maps an offset to a bank index; NUM_REGS means unmapped
   function automatic logic [2:0] decode_index(input logic [ADDR_W-1:0] a);
      if (a == OFS_OUT1_PINS) begin
         decode_index = 3'(IDX_OUT1_PINS);
      end else if (a == OFS_OUT4_MAIN) begin
         decode_index = 3'(IDX_OUT4_MAIN);
      end else if (a == OFS_OUT4_PINS) begin
         decode_index = 3'(IDX_OUT4_PINS);
      end else if (a == OFS_OUT2_MAIN) begin
         decode_index = 3'(IDX_OUT2_MAIN);
      end else if (a == OFS_OUT2_PINS) begin
         decode_index = 3'(IDX_OUT2_PINS);
      end else begin
         decode_index = 3'(NUM_REGS);
      end
   endfunction : decode_index

   // Tree is good when every input is good or masked
   function automatic logic tree_good(input logic [7:0] vals, input logic [7:0] mask);
      tree_good = &(vals | mask);
   endfunction : tree_good

   logic [DATA_W-1:0] mask_q [NUM_REGS];
   logic [DATA_W-1:0] mask_d [NUM_REGS];
   load_state_e       load_q, load_d;
   logic              shared_sel_q, shared_sel_d;
   logic [2:0]        host_ctrl_q, host_ctrl_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic              hit_q, hit_d;
   logic [IN_W-1:0]   sync1_q, sync2_q;
   logic [IN_W-1:0]   raw_in;
   logic [2:0]        out_q, out_d;
   logic [2:0]        idx;
   logic [7:0]        main_rails, pins_rails;
   logic              shared_pg;
   // Synchronised copies, one name per input, so no bit index is hand-counted
   logic [5:0]        conv_sync;
   logic              switch_a_one_sync;
   logic              reg_a_two_sync;
   logic              reg_a_three_sync;
   logic              reg_a_one_sync;
   logic              load_switch_one_sync;
   logic              load_switch_two_sync;
   logic              termination_sync;
   logic              pin_one_sync;
   logic              pin_two_sync;
   logic              pin_four_sync;
   logic              pin_five_sync;
   logic [2:0]        level_sync;

   // Gather asynchronous inputs for the two-stage synchroniser
   assign raw_in = {converter_pg, switch_a_one_pg, regulator_a_two_pg,
                    regulator_a_three_pg, regulator_a_one_pg, load_switch_one_pg,
                    load_switch_two_pg, termination_regulator_pg, control_input_one,
                    control_input_two, control_input_four, control_input_five,
                    host_level};

   // Two flip-flops before any logic reads the inputs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sync1_q <= '0;
         sync2_q <= '0;
      end else begin
         sync1_q <= raw_in;
         sync2_q <= sync1_q;
      end
   end

   // Split the synchronised word in the same order it was gathered;
   // the widths must add up to IN_W or every field below slides
   assign {conv_sync, switch_a_one_sync, reg_a_two_sync, reg_a_three_sync, reg_a_one_sync,
           load_switch_one_sync, load_switch_two_sync, termination_sync, pin_one_sync,
           pin_two_sync, pin_four_sync, pin_five_sync, level_sync} = sync2_q;

   // Shared slot follows the configured rail
   assign shared_pg = (shared_sel_q == SHARED_IS_SWITCH2) ? load_switch_two_sync
                                                          : reg_a_one_sync;

   // Main rails: a2, a1 switch, converters six..one
   assign main_rails = {reg_a_two_sync, switch_a_one_sync, conv_sync};
   // Pins and rails: pin5, pin4, pin2, pin1, termination, shared, switch1, a3
   assign pins_rails = {pin_five_sync, pin_four_sync, pin_two_sync, pin_one_sync,
                        termination_sync, shared_pg, load_switch_one_sync, reg_a_three_sync};

   assign idx = decode_index(reg_addr);

   // Next state for the register bank, factory load and read port
   always_comb begin
      load_d       = load_q;
      shared_sel_d = shared_sel_q;
      host_ctrl_d  = host_ctrl_q;
      rdata_d      = READ_IDLE;
      hit_d        = 1'b0;
      for (int i = 0; i < NUM_REGS; i++) begin
         mask_d[i] = mask_q[i];
      end
      case (load_q)
         LOAD_WAIT: begin
            // Factory values captured on the first edge after reset
            for (int i = 0; i < NUM_REGS; i++) begin
               mask_d[i] = factory_masks[8*i +: 8];
            end
            shared_sel_d = factory_shared_sel;
            host_ctrl_d  = factory_host_ctrl;
            load_d       = LOAD_DONE;
         end
         default: begin
            if (reg_wr && idx < 3'(NUM_REGS)) begin
               mask_d[idx] = reg_wdata;
               hit_d       = 1'b1;
            end else if (reg_rd && idx < 3'(NUM_REGS)) begin
               rdata_d = mask_q[idx];
               hit_d   = 1'b1;
            end
         end
      endcase
   end

   // Register the bank and control state
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            mask_q[i] <= '1;
         end
         load_q       <= LOAD_WAIT;
         shared_sel_q <= SHARED_IS_REG_A1;
         host_ctrl_q  <= '0;
         rdata_q      <= READ_IDLE;
         hit_q        <= 1'b0;
      end else begin
         for (int i = 0; i < NUM_REGS; i++) begin
            mask_q[i] <= mask_d[i];
         end
         load_q       <= load_d;
         shared_sel_q <= shared_sel_d;
         host_ctrl_q  <= host_ctrl_d;
         rdata_q      <= rdata_d;
         hit_q        <= hit_d;
      end
   end

   // Output trees; output one's main-rail mask lives outside this bank
   always_comb begin
      out_d[2] = tree_good(pins_rails, mask_q[IDX_OUT1_PINS]);
      out_d[1] = tree_good(main_rails, mask_q[IDX_OUT4_MAIN])
               & tree_good(pins_rails, mask_q[IDX_OUT4_PINS]);
      out_d[0] = tree_good(main_rails, mask_q[IDX_OUT2_MAIN])
               & tree_good(pins_rails, mask_q[IDX_OUT2_PINS]);
      for (int i = 0; i < 3; i++) begin
         // Host level only where factory set host control
         if (host_ctrl_q[i]) begin
            out_d[i] = level_sync[i];
         end
      end
      if (load_q == LOAD_WAIT) begin
         out_d = '0;
      end
   end

   // Register the output pins
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         out_q <= '0;
      end else begin
         out_q <= out_d;
      end
   end

   assign reg_rdata          = rdata_q;
   assign reg_hit            = hit_q;
   assign status_output_one  = out_q[2];
   assign status_output_four = out_q[1];
   assign status_output_two  = out_q[0];

endmodule : pg_mask_bank

// *** shared/pg_mask_pkg.sv ***
// Constants for the power-good tree mask bank: offsets, field positions,
// variant codes. Assumes an 8-bit register port of the serial host interface.
package pg_mask_pkg;
   localparam int          ADDR_W            = 8;
   localparam int          DATA_W            = 8;
   localparam int          NUM_REGS          = 5;
   // Register offsets
   localparam logic [7:0]  OFS_OUT1_PINS     = 8'hA5;
   localparam logic [7:0]  OFS_OUT4_MAIN     = 8'hA6;
   localparam logic [7:0]  OFS_OUT4_PINS     = 8'hA7;
   localparam logic [7:0]  OFS_OUT2_MAIN     = 8'hA8;
   localparam logic [7:0]  OFS_OUT2_PINS     = 8'hA9;
   // Register indexes within the bank
   localparam int          IDX_OUT1_PINS     = 0;
   localparam int          IDX_OUT4_MAIN     = 1;
   localparam int          IDX_OUT4_PINS     = 2;
   localparam int          IDX_OUT2_MAIN     = 3;
   localparam int          IDX_OUT2_PINS     = 4;
   // Pins-and-rails layout: bit 7 pin five, 6 pin four, 5 pin two, 4 pin one,
   // 3 termination, 2 shared rail, 1 load switch one, 0 regulator a3
   localparam int          BIT_SHARED_RAIL   = 2;
   localparam logic [7:0]  READ_IDLE         = 8'h00;
   // Shared slot selection: 0 picks regulator a1, 1 picks load switch two
   localparam logic        SHARED_IS_REG_A1  = 1'b0;
   localparam logic        SHARED_IS_SWITCH2 = 1'b1;
endpackage : pg_mask_pkg

// *** tb/pg_mask_bank_checker.sv ***
// Checker for the mask bank: host answers, reset outputs, host-level mode.
// Assumes it is bound to pg_mask_bank and sees only that module's ports.
`timescale 1ns/1ps
module pg_mask_bank_checker
   import pg_mask_pkg::*;
(
   input  wire logic              clock,              // Logic clock
   input  wire logic              rst,                // Async reset
   input  wire logic [ADDR_W-1:0] reg_addr,           // Register offset
   input  wire logic              reg_wr,             // Write strobe
   input  wire logic              reg_rd,             // Read strobe
   input  wire logic [DATA_W-1:0] reg_rdata,          // Read data
   input  wire logic              reg_hit,            // Hit pulse
   input  wire logic [2:0]        factory_host_ctrl,  // Host-level modes
   input  wire logic [2:0]        host_level,         // Level bits
   input  wire logic              status_output_one,  // Output one
   input  wire logic              status_output_four, // Output four
   input  wire logic              status_output_two   // Output two
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   // Offset falls inside the bank
   logic mapped;
   assign mapped = (reg_addr >= OFS_OUT1_PINS) && (reg_addr <= OFS_OUT2_PINS);
   // Bus answers
   chk_unmapped_no_hit: assert property ((reg_wr || reg_rd) && !mapped |=> !reg_hit)
      else $error("unmapped access was answered");
   chk_rdata_idle_low: assert property (!reg_rd |=> reg_rdata == READ_IDLE)
      else $error("read data without a read");
   chk_mapped_hit_pulse: assert property (
      (reg_wr || reg_rd) && mapped && !$past(rst) |=> reg_hit)
      else $error("mapped access not answered");
   chk_hit_has_cause: assert property (reg_hit |-> $past(reg_wr || reg_rd) && $past(mapped))
      else $error("hit without mapped strobe");
   chk_rdata_from_read: assert property (
      reg_rdata != READ_IDLE |-> $past(reg_rd) && !$past(reg_wr))
      else $error("read data not caused by a read");
   chk_reset_outs_low: assert property ($fell(rst) |=>
      !status_output_one && !status_output_two && !status_output_four)
      else $error("outputs not low after reset");
   // Host-level mode follows level bits three edges later
   chk_host_out_one: assert property (
      factory_host_ctrl[2] [*5] |-> status_output_one == $past(host_level[2], 3))
      else $error("output one not following its level bit");
   chk_host_out_four: assert property (
      factory_host_ctrl[1] [*5] |-> status_output_four == $past(host_level[1], 3))
      else $error("output four not following its level bit");
   chk_host_out_two: assert property (
      factory_host_ctrl[0] [*5] |-> status_output_two == $past(host_level[0], 3))
      else $error("output two not following its level bit");
   // Main scenarios reached
   cov_mapped_read: cover property (reg_rd && mapped ##1 reg_hit);
   cov_unmapped_write: cover property (reg_wr && !mapped);
   cov_host_level_high: cover property (factory_host_ctrl[0] && status_output_two);
endmodule : pg_mask_bank_checker

// *** tb/pg_mask_bank_tb_top.sv ***
// Testbench for the mask bank: register access, trees, shared slot, host mode.
// Assumes the bank alone; every input is driven on the falling edge.
`timescale 1ns/1ps
module pg_mask_bank_tb_top;
   import pg_mask_pkg::*;
   logic              clock = 0, rst = 1, reg_wr = 0, reg_rd = 0, sel = 0;
   logic [ADDR_W-1:0] reg_addr = 0;
   logic [7:0]        reg_wdata = 0, main = 0, pins = 0, reg_rdata, m [5];
   logic              reg_hit, o1, o4, o2;
   logic [39:0]       fm = 40'h5A3C96E10F;
   logic [2:0]        hc = 0, hl = 0;
   int                num_errors = 0, comparisons = 0;
   // Clock, 50 ns period
   always #25 clock = ~clock;
   // Shared slot: the unselected rail always shows the opposite level
   pg_mask_bank DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
      .factory_masks(fm), .factory_shared_sel(sel), .factory_host_ctrl(hc), .host_level(hl),
      .converter_pg(main[5:0]), .switch_a_one_pg(main[6]), .regulator_a_two_pg(main[7]),
      .regulator_a_three_pg(pins[0]), .regulator_a_one_pg(pins[2] ^ sel),
      .load_switch_one_pg(pins[1]), .load_switch_two_pg(pins[2] ^ !sel),
      .termination_regulator_pg(pins[3]), .control_input_one(pins[4]),
      .control_input_two(pins[5]), .control_input_four(pins[6]),
      .control_input_five(pins[7]), .status_output_one(o1), .status_output_four(o4),
      .status_output_two(o2));
   // Counted comparison
   task automatic check(string what, logic [7:0] exp, logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // One host access; answer judged one edge after the strobe
   task automatic acc(logic wr, int a, logic [7:0] d, logic [7:0] exp);
      logic hit;
      hit = (a >= OFS_OUT1_PINS) && (a <= OFS_OUT2_PINS);
      @(negedge clock);
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {wr, !wr, 8'(a), d};
      @(negedge clock);
      {reg_wr, reg_rd} = 2'h0;
      check("hit", {7'h00, hit}, {7'h00, reg_hit});
      check("rdata", wr ? 8'h00 : exp, reg_rdata);
   endtask : acc
   // Expected tree levels of outputs one, four, two
   function automatic logic [2:0] tree();
      tree = {&(pins | m[0]), &(main | m[1]) & &(pins | m[2]), &(main | m[3]) & &(pins | m[4])};
   endfunction : tree
   task automatic settle();
      repeat (4) @(negedge clock);
      check("tree", {5'h00, tree()}, {5'h00, o1, o4, o2});
   endtask : settle
   task automatic do_reset();
      @(negedge clock);
      rst = 1;
      repeat (16) @(negedge clock);
      rst = 0;
      for (int i = 0; i < 5; i++) m[i] = fm[8*i +: 8];
      repeat (2) @(negedge clock);
   endtask : do_reset
   // Factory values, read and write of every mask, unmapped neighbours
   task automatic t_regs();
      for (int i = 0; i < 5; i++) acc(0, OFS_OUT1_PINS + i, 8'h00, m[i]);
      for (int i = 0; i < 5; i++) begin
         m[i] = 8'(8'h33 * (i + 1));
         acc(1, OFS_OUT1_PINS + i, m[i], 8'h00);
      end
      for (int i = 0; i < 5; i++) acc(0, OFS_OUT1_PINS + i, 8'h00, m[i]);
      acc(1, 8'hA4, 8'hFF, 8'h00);
      acc(1, 8'hAA, 8'hFF, 8'h00);
      acc(0, 8'hA4, 8'h00, 8'h00);
      acc(0, 8'hAA, 8'h00, 8'h00);
      $display("test regs done");
   endtask : t_regs
   // Each tree input dropped, then masked by its own bit
   task automatic t_tree();
      for (int i = 0; i < 5; i++) begin
         m[i] = 8'h00;
         acc(1, OFS_OUT1_PINS + i, 8'h00, 8'h00);
      end
      for (int r = 0; r < 5; r++) begin
         for (int b = 0; b < 8; b++) begin
            {main, pins} = 16'hFFFF;
            if (r == 1 || r == 3) main[b] = 1'b0;
            else pins[b] = 1'b0;
            settle();
            m[r][b] = 1'b1;
            acc(1, OFS_OUT1_PINS + r, m[r], 8'h00);
            settle();
            m[r][b] = 1'b0;
            acc(1, OFS_OUT1_PINS + r, m[r], 8'h00);
         end
      end
      $display("test tree done, shared select %0d", sel);
   endtask : t_tree
   // Host-level mode on all outputs with every rail bad except the unselected regulator a1
   task automatic t_host();
      hc = 3'b111;
      {main, pins} = 16'h0000;
      do_reset();
      for (int v = 0; v < 8; v++) begin
         hl = 3'(v);
         repeat (4) @(negedge clock);
         check("host", {5'h00, hl}, {5'h00, o1, o4, o2});
      end
      $display("test host done");
   endtask : t_host
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : test_done
   // Main sequence, then a watchdog well beyond its length
   initial begin
      do_reset();
      t_regs();
      t_tree();
      sel = 1;
      do_reset();
      t_tree();
      t_host();
      test_done();
   end
   initial begin
      #500000;
      num_errors++;
      test_done();
   end
endmodule : pg_mask_bank_tb_top
bind pg_mask_bank pg_mask_bank_checker chk (.clock(clock), .rst(rst), .reg_addr(reg_addr),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_hit(reg_hit),
   .factory_host_ctrl(factory_host_ctrl), .host_level(host_level),
   .status_output_one(status_output_one), .status_output_four(status_output_four),
   .status_output_two(status_output_two));
